// File: shared/ths_map.vh
// constants for the two-hand sync monitor
// Function
// - ready only with supply present and feedback loop closed
// - a cycle starts only while both safety outputs are off
// - energize outputs when both buttons pressed within 0.5 s
// - one button only, or presses over 0.5 s apart, keeps outputs off
// - open feedback loop blocks energizing the outputs
// - any detected fault keeps the outputs de-energized
// - releasing either button drops both outputs at once
// - new cycle needs both buttons released and loop closed
// - self-monitoring finds each single fault by the next actuation
// - two redundant outputs with cyclic contact-state monitoring
// - button short circuits and ground faults block the outputs
// - outputs drop within under 20 ms after a release
// - outputs energize within under 20 ms after valid actuation
`ifndef THS_MAP_VH
`define THS_MAP_VH
`define THS_CLK_HZ        100000000
`define THS_SYNC_MS       500
`define THS_SYNC_CYC      ((`THS_CLK_HZ / 1000) * `THS_SYNC_MS)
`define THS_DEB_US        1000
`define THS_DEB_CYC       ((`THS_CLK_HZ / 1000000) * `THS_DEB_US)
`define THS_RESP_MS       20
`define THS_RESP_CYC      ((`THS_CLK_HZ / 1000) * `THS_RESP_MS)
`define THS_CHK_US        2000
`define THS_CHK_CYC       ((`THS_CLK_HZ / 1000000) * `THS_CHK_US)
`define THS_ST_IDLE       3'h0
`define THS_ST_ARMED      3'h1
`define THS_ST_WAIT2      3'h2
`define THS_ST_ON         3'h3
`define THS_ST_REARM      3'h4
`define THS_ST_FAULT      3'h5
`endif

// File: logic/ths_debounce.v
// debounce filter for one button input
`timescale 1ns/1ps
module ths_debounce #(
    parameter CNT_W = 17,
    parameter [CNT_W-1:0] LIMIT = 17'd100000
) (
    input  wire sys_clk_i,
    input  wire rstn_i,
    input  wire ce_i,
    input  wire raw_i,
    output reg  clean_o
);
    reg [CNT_W-1:0] cnt_q;
    // =====================================
    // stable-time filter
    // =====================================
    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            cnt_q   <= {CNT_W{1'b0}};
            clean_o <= 1'b0;
        end else if (ce_i) begin
            if (raw_i == clean_o) begin
                cnt_q <= {CNT_W{1'b0}};
            end else if (cnt_q >= LIMIT - 1'b1) begin
                cnt_q   <= {CNT_W{1'b0}};
                clean_o <= raw_i;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule // ths_debounce

// File: logic/ths_monitor.v
// two-hand sync monitor top
`timescale 1ns/1ps
`include "ths_map.vh"
module ths_monitor #(
    parameter SYNC_CYC = `THS_SYNC_CYC,
    parameter DEB_CYC  = `THS_DEB_CYC,
    parameter CHK_CYC  = `THS_CHK_CYC
) (
    input  wire       sys_clk_i,
    input  wire       rstn_i,
    input  wire       ce_i,
    input  wire       supply_ok_i,
    input  wire       first_hand_button_no_i,
    input  wire       first_hand_button_nc_i,
    input  wire       second_hand_button_no_i,
    input  wire       second_hand_button_nc_i,
    input  wire       feedback_loop_return_i,
    input  wire [1:0] contact_state_i,
    output reg        feedback_loop_out_o,
    output reg  [1:0] safety_out_o,
    output reg        ready_o,
    output reg        fault_o
);
    localparam ST_IDLE  = `THS_ST_IDLE;
    localparam ST_ARMED = `THS_ST_ARMED;
    localparam ST_WAIT2 = `THS_ST_WAIT2;
    localparam ST_ON    = `THS_ST_ON;
    localparam ST_REARM = `THS_ST_REARM;
    localparam ST_FAULT = `THS_ST_FAULT;

    wire       b1_no;
    wire       b1_nc;
    wire       b2_no;
    wire       b2_nc;
    wire       b1_nc_n;
    wire       b2_nc_n;
    reg  [2:0] st_q;
    reg  [2:0] st_d;
    reg  [26:0] win_q;
    reg  [26:0] win_d;
    reg  [20:0] chk_q;
    reg  [1:0] cmd_q;
    reg        flt_q;
    reg        flt_d;
    wire       b1_on;
    wire       b2_on;
    wire       b1_off;
    wire       b2_off;
    wire       in_flt;
    wire       cnt_flt;
    wire       loop_ok;
    wire       on_ok;

    // =====================================
    // debounced button contacts
    // =====================================
    // debounce each contact
    ths_debounce #(.CNT_W(27), .LIMIT(DEB_CYC[26:0])) u_d1no (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .ce_i      (ce_i),
        .raw_i     (first_hand_button_no_i),
        .clean_o   (b1_no)
    );
    ths_debounce #(.CNT_W(27), .LIMIT(DEB_CYC[26:0])) u_d1nc (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .ce_i      (ce_i),
        .raw_i     (~first_hand_button_nc_i),
        .clean_o   (b1_nc_n)
    );
    ths_debounce #(.CNT_W(27), .LIMIT(DEB_CYC[26:0])) u_d2no (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .ce_i      (ce_i),
        .raw_i     (second_hand_button_no_i),
        .clean_o   (b2_no)
    );
    ths_debounce #(.CNT_W(27), .LIMIT(DEB_CYC[26:0])) u_d2nc (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .ce_i      (ce_i),
        .raw_i     (~second_hand_button_nc_i),
        .clean_o   (b2_nc_n)
    );

    // =====================================
    // contact decoding
    // =====================================
    // nc filters run inverted so reset reads as released
    assign b1_nc  = ~b1_nc_n;
    assign b2_nc  = ~b2_nc_n;
    assign b1_on  = b1_no & ~b1_nc;
    assign b2_on  = b2_no & ~b2_nc;
    assign b1_off = ~b1_no & b1_nc;
    assign b2_off = ~b2_no & b2_nc;

    // =====================================
    // fault and loop detection
    // =====================================
    // both contacts equal means short or ground fault
    assign in_flt = (b1_no == b1_nc) | (b2_no == b2_nc);
    // loop closed only when return follows the driven level
    assign loop_ok = feedback_loop_out_o & feedback_loop_return_i;
    // contact state must match command after settle time
    assign cnt_flt = (chk_q == 21'd0) & (contact_state_i != cmd_q);

    // =====================================
    // control sequence
    // =====================================
    always @* begin
        st_d  = st_q;
        win_d = win_q;
        flt_d = flt_q | in_flt | cnt_flt;
        case (st_q)
            ST_IDLE: begin
                // wait for both released and loop closed
                if (b1_off && b2_off && loop_ok && supply_ok_i) begin
                    st_d = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (b1_on || b2_on) begin
                    win_d = 27'd0;
                    st_d  = ST_WAIT2;
                end
                if (!loop_ok || !supply_ok_i) begin
                    st_d = ST_IDLE;
                end
            end
            ST_WAIT2: begin
                win_d = win_q + 27'd1;
                if (b1_on && b2_on && cmd_q == 2'b00) begin
                    st_d = ST_ON;
                end else if (win_q >= SYNC_CYC[26:0] - 27'd1
                             || (!b1_on && !b2_on)) begin
                    st_d = ST_REARM;
                end
            end
            ST_ON: begin
                if (!b1_on || !b2_on) begin
                    st_d = ST_REARM;
                end
            end
            ST_REARM: begin
                if (b1_off && b2_off) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_FAULT;
            end
        endcase
        if (flt_d) begin
            st_d = ST_FAULT;
        end
    end

    // =====================================
    // state and indications
    // =====================================
    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            st_q                <= ST_IDLE;
            win_q               <= 27'd0;
            flt_q               <= 1'b0;
            ready_o             <= 1'b0;
            fault_o             <= 1'b0;
            feedback_loop_out_o <= 1'b0;
        end else if (ce_i) begin
            st_q                <= st_d;
            win_q               <= win_d;
            flt_q               <= flt_d;
            feedback_loop_out_o <= 1'b1;
            fault_o             <= flt_d;
            ready_o <= supply_ok_i & loop_ok & ~flt_d;
        end
    end

    // =====================================
    // output stage
    // =====================================
    // energize only from off with loop closed
    assign on_ok = (st_d == ST_ON) & ~flt_d
                   & ((cmd_q == 2'b11) | loop_ok);

    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            cmd_q        <= 2'b00;
            safety_out_o <= 2'b00;
        end else if (ce_i) begin
            // outputs follow next state in one cycle
            if (on_ok) begin
                cmd_q        <= 2'b11;
                safety_out_o <= 2'b11;
            end else begin
                cmd_q        <= 2'b00;
                safety_out_o <= 2'b00;
            end
        end
    end

    // =====================================
    // contact readback timer
    // =====================================
    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            chk_q <= 21'd0;
        end else if (ce_i) begin
            // recheck contacts after every command change
            if (on_ok != (cmd_q == 2'b11)) begin
                chk_q <= CHK_CYC[20:0];
            end else if (chk_q != 21'd0) begin
                chk_q <= chk_q - 21'd1;
            end
        end
    end
endmodule // ths_monitor

// File: test/ths_partner.sv
// far-side model: two buttons and downstream contactors
`timescale 1ns/1ps
module ths_partner (
    input  logic       sys_clk_i,
    input  logic       press1_i,
    input  logic       press2_i,
    input  logic       short_i,
    input  logic       loop_open_i,
    input  logic       stuck_i,
    input  logic       loop_drive_i,
    input  logic [1:0] cmd_i,
    output logic       b1_no_o,
    output logic       b1_nc_o,
    output logic       b2_no_o,
    output logic       b2_nc_o,
    output logic       loop_ret_o,
    output logic [1:0] contact_o
);
    logic [1:0] d1_q = 2'h0;
    logic [1:0] d2_q = 2'h0;
    assign b1_no_o = press1_i | short_i;
    assign b1_nc_o = ~press1_i;
    assign b2_no_o = press2_i;
    assign b2_nc_o = ~press2_i;
    assign loop_ret_o = loop_drive_i & ~loop_open_i;
    always @(posedge sys_clk_i) begin
        d1_q <= cmd_i;
        d2_q <= d1_q;
    end
    assign contact_o = stuck_i ? 2'h0 : d2_q;
endmodule // ths_partner

// File: test/ths_monitor_chk.sv
// port assertions for the two-hand monitor
`timescale 1ns/1ps
module ths_monitor_chk (
    input wire       sys_clk_i,
    input wire       rstn_i,
    input wire       supply_ok_i,
    input wire       first_hand_button_no_i,
    input wire       first_hand_button_nc_i,
    input wire       second_hand_button_no_i,
    input wire       feedback_loop_return_i,
    input wire       feedback_loop_out_o,
    input wire [1:0] safety_out_o,
    input wire       ready_o,
    input wire       fault_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    a_ready_cause: assert property (
        ready_o |-> $past(supply_ok_i & feedback_loop_return_i))
        else $error("ready without supply and closed loop");
    a_loop_driven: assert property (
        $past(rstn_i) |-> feedback_loop_out_o)
        else $error("loop drive low after reset");
    a_outs_paired: assert property (
        safety_out_o == 2'h0 || safety_out_o == 2'h3)
        else $error("safety outputs disagree");
    a_rise_ready: assert property (
        $rose(safety_out_o[0]) |-> $past(feedback_loop_return_i)
            && !fault_o && $past(safety_out_o) == 2'h0)
        else $error("outputs energized from blocked state");
    a_fault_blocks: assert property (
        fault_o |=> safety_out_o == 2'h0)
        else $error("outputs on with fault");
    a_fault_holds: assert property (
        fault_o |=> fault_o)
        else $error("fault cleared without reset");
    a_release_drop: assert property (
        (!first_hand_button_no_i || !second_hand_button_no_i) [*7]
        |-> safety_out_o == 2'h0)
        else $error("outputs on after release");
    a_short_fault: assert property (
        (first_hand_button_no_i == first_hand_button_nc_i) [*8] |-> fault_o)
        else $error("button short not flagged");
endmodule // ths_monitor_chk
bind ths_monitor ths_monitor_chk chk_u (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .supply_ok_i(supply_ok_i),
    .first_hand_button_no_i(first_hand_button_no_i),
    .first_hand_button_nc_i(first_hand_button_nc_i),
    .second_hand_button_no_i(second_hand_button_no_i),
    .feedback_loop_return_i(feedback_loop_return_i),
    .feedback_loop_out_o(feedback_loop_out_o), .safety_out_o(safety_out_o),
    .ready_o(ready_o), .fault_o(fault_o));

// File: test/ths_monitor_tb.sv
// self-checking bench for the two-hand monitor
`timescale 1ns/1ps
module ths_monitor_tb;
    localparam int SYNC = 200;
    logic       clk, rstn, sup, p1, p2, sh, lo, st;
    logic       b1n, b1c, b2n, b2c, lr, lod, rdy, flt;
    logic [1:0] cs, so;
    int         fail_count = 0;
    int         n_tests = 0;
    int         gap;
    ths_monitor #(.SYNC_CYC(SYNC), .DEB_CYC(4), .CHK_CYC(20)) dut_u (
        .sys_clk_i(clk), .rstn_i(rstn), .ce_i(1'b1), .supply_ok_i(sup),
        .first_hand_button_no_i(b1n), .first_hand_button_nc_i(b1c),
        .second_hand_button_no_i(b2n), .second_hand_button_nc_i(b2c),
        .feedback_loop_return_i(lr), .contact_state_i(cs),
        .feedback_loop_out_o(lod), .safety_out_o(so), .ready_o(rdy),
        .fault_o(flt));
    ths_partner peer_u (.sys_clk_i(clk), .press1_i(p1), .press2_i(p2),
        .short_i(sh), .loop_open_i(lo), .stuck_i(st), .loop_drive_i(lod),
        .cmd_i(so), .b1_no_o(b1n), .b1_nc_o(b1c), .b2_no_o(b2n),
        .b2_nc_o(b2c), .loop_ret_o(lr), .contact_o(cs));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    function logic [1:0] exp_on(input int g);
        return (g <= SYNC) ? 2'h3 : 2'h0;
    endfunction
    task go(input int n);
        repeat (n) @(posedge clk);
    endtask
    task chk(input string nm, input logic [1:0] e, input logic [1:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task pair(input int g, input logic [1:0] e);
        go(1);
        p1 <= 1;
        go(g);
        p2 <= 1;
        go(10);
        #1 chk("safety_out", e, so);
    endtask
    task rel;
        go(1);
        p1 <= 0;
        p2 <= 0;
        go(10);
    endtask
    task print_verdict;
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        fail_count++;
        print_verdict;
    end
    initial begin
        void'($urandom(36));
        rstn = 0; sup = 1; p1 = 0; p2 = 0; sh = 0; lo = 0; st = 0;
        go(3);
        rstn <= 1;
        go(12);
        #1 chk("ready", 2'h1, {1'b0, rdy});
        chk("loop_out", 2'h1, {1'b0, lod});
        go(1);
        lo <= 1;
        go(3);
        #1 chk("ready", 2'h0, {1'b0, rdy});
        pair(0, 2'h0);
        rel;
        lo <= 0;
        go(10);
        for (int i = 0; i < 4; i++) begin
            gap = $urandom % 191;
            pair(gap, exp_on(gap));
            go(1);
            if (i[0]) p1 <= 0; else p2 <= 0;
            go(7);
            #1 chk("safety_out", 2'h0, so);
            pair(0, 2'h0);
            rel;
        end
        pair(SYNC, exp_on(SYNC));
        rel;
        pair(SYNC + 1, exp_on(SYNC + 1));
        rel;
        pair(210, exp_on(210));
        rel;
        pair(300, 2'h0);
        go(1);
        p2 <= 0;
        go(300);
        #1 chk("safety_out", 2'h0, so);
        rel;
        st <= 1;
        pair(0, 2'h3);
        go(40);
        #1 chk("fault", 2'h2, {flt, so[0]});
        rel;
        st <= 0;
        rstn <= 0;
        go(2);
        rstn <= 1;
        sh <= 1;
        go(12);
        #1 chk("fault", 2'h1, {1'b0, flt});
        pair(0, 2'h0);
        print_verdict;
    end
endmodule // ths_monitor_tb
